// ---- rtl/twi_slave_tx.sv ----
// Slave transmitter engine of a byte-oriented two-wire interface with status codes.
// Assumes open-drain lines resolved outside; control writes come from logic on clk_sys_i.
//
// Overview of operation
// - Own read address acked: status a8, done.
// - Arbitration lost then read-addressed: status b0.
// - Byte sent, master ACK: status b8, done.
// - Byte sent, master NOT ACK: status c0, done.
// - Final byte answered ACK: status c8.
// - Software loads byte, clears done; no ack-enable means last.
// - Clear with ack-enable set sends byte, expects ACK.
// - After c0/c8 without ack-enable, ignore all addresses.
// - After c0/c8 with ack-enable, recognise own address.
// - Start-request then issues START once bus free.
// - Status reads f8 whenever done is clear.
// - Misplaced START or STOP reports status 00.
// - Bus error sets the done flag.
// - Recovery: not addressed, stop-request self-clears.
// - Recovery releases lines, sends no STOP.
// - Status low three bits always read zero.
// - Done set stretches clock low, except on bus error; clear resumes.
// - Clocking after final byte is ignored, reads ones.
`timescale 1ns/1ps
module twi_slave_tx
  import twi_slave_tx_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [6:0] own_slave_address_i,
  input wire logic general_call_enable_i,
  input wire logic arb_lost_i,
  input wire logic ctrl_wr_i,
  input wire ctrl_t ctrl_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] bus_status_reg_o,
  output logic job_done_flag_o,
  output logic ack_enable_o,
  output logic start_request_o,
  output logic stop_request_o,
  output logic start_sent_o
);

  logic scl_m, scl_q, scl_p, sda_m, sda_q, sda_p;
  state_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [7:0] shift_data_reg, next_data;
  logic [7:0] code, next_code;
  logic done, next_done;
  logic last, next_last;
  logic ackd, next_ackd;
  logic arb, next_arb;
  logic busy, next_busy;
  logic sent, next_sent;
  logic [9:0] start_cnt, next_start_cnt;
  ctrl_t ctl, next_ctl;
  line_drive_t drv, next_drv;

  wire scl_rise = scl_q & ~scl_p;
  wire scl_fall = ~scl_q & scl_p;
  wire start_det = scl_q & scl_p & sda_p & ~sda_q;
  wire stop_det = scl_q & scl_p & ~sda_p & sda_q;
  wire sw_clear = ctrl_wr_i & ctrl_i.job_done_clr;
  wire own_hit = sh[6:0] == own_slave_address_i;
  wire gc_hit = general_call_enable_i & (sh[6:0] == GENERAL_CALL_ADDRESS);
  wire addr_hit = ctl.ack_enable & sda_q & (own_hit | gc_hit);
  wire send_more = (code == ST_OWN_READ_ACK) | (code == ST_ARB_LOST_READ) | (code == ST_DATA_ACK);
  wire in_frame = (st == S_ADDR_ACK) | (st == S_TX) | (st == S_TX_ACK) | ((st == S_ADDR) & (cnt != BIT_FIRST));
  wire illegal = (start_det | stop_det) & in_frame;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_data = data_wr_i ? data_i : shift_data_reg;
    next_code = code;
    next_done = done;
    next_last = last;
    next_ackd = ackd;
    next_arb = arb | arb_lost_i;
    next_busy = start_det ? 1'b1 : (stop_det ? 1'b0 : busy);
    next_sent = sent;
    next_start_cnt = start_cnt;
    next_ctl = ctl;
    next_drv = drv;
    if (ctrl_wr_i) begin
      next_ctl = ctrl_i;
      next_ctl.job_done_clr = 1'b0;
    end
    if (sw_clear) begin
      next_done = 1'b0;
    end
    case (st)
      S_IDLE: begin
        if (start_det) begin
          next_st = S_ADDR;
          next_cnt = BIT_FIRST;
        end else if (ctl.start_request && !busy) begin
          next_st = S_START;
          next_start_cnt = '0;
          next_drv.sda_oe = 1'b1;
        end
      end
      S_ADDR: begin
        if (start_det) begin
          next_cnt = BIT_FIRST;
        end else if (scl_rise) begin
          next_sh = {sh[6:0], sda_q};
          if (cnt != BIT_LAST) begin
            next_cnt = cnt + 4'h1;
          end else if (addr_hit) begin
            next_st = S_ADDR_ACK;
            next_cnt = ACK_DRIVE;
          end else begin
            next_st = S_IDLE;
          end
        end
      end
      S_ADDR_ACK: begin
        if (scl_fall && cnt == ACK_DRIVE) begin
          next_drv.sda_oe = 1'b1;
          next_cnt = ACK_DONE;
        end else if (scl_fall) begin
          next_drv.sda_oe = 1'b0;
          next_drv.scl_oe = 1'b1;
          next_st = S_WAIT;
          next_done = 1'b1;
          next_code = arb ? ST_ARB_LOST_READ : ST_OWN_READ_ACK;
          next_arb = 1'b0;
        end
      end
      S_WAIT: begin
        if (sw_clear && send_more) begin
          next_st = S_TX;
          next_sh = next_data;
          next_last = ~ctrl_i.ack_enable;
          next_cnt = BIT_FIRST;
          next_drv.sda_oe = ~next_data[7];
          next_drv.scl_oe = 1'b0;
        end else if (sw_clear) begin
          next_st = S_IDLE;
          next_drv = '0;
        end
      end
      S_TX: begin
        if (scl_fall && cnt == BIT_LAST) begin
          next_drv.sda_oe = 1'b0;
          next_st = S_TX_ACK;
        end else if (scl_fall) begin
          next_sh = {sh[6:0], 1'b0};
          next_drv.sda_oe = ~sh[6];
          next_cnt = cnt + 4'h1;
        end
      end
      S_TX_ACK: begin
        if (scl_rise) begin
          next_ackd = ~sda_q;
        end else if (scl_fall) begin
          next_st = S_WAIT;
          next_done = 1'b1;
          next_drv.scl_oe = 1'b1;
          next_code = !ackd ? ST_DATA_NACK : (last ? ST_LAST_ACK : ST_DATA_ACK);
        end
      end
      S_ERR: begin
        if (sw_clear && ctrl_i.stop_request) begin
          next_st = S_IDLE;
          next_ctl.stop_request = 1'b0;
          next_drv = '0;
        end
      end
      S_START: begin
        if (start_cnt != START_HOLD_LAST) begin
          next_start_cnt = start_cnt + 10'h001;
        end else if (!sent) begin
          next_drv.scl_oe = 1'b1;
          next_sent = 1'b1;
        end else if (sw_clear) begin
          next_st = S_IDLE;
          next_sent = 1'b0;
          next_drv = '0;
        end
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
    if (illegal) begin
      next_st = S_ERR;
      next_done = 1'b1;
      next_code = ST_BUS_ERROR;
      next_drv = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    scl_m <= scl_i;
    scl_q <= scl_m;
    scl_p <= scl_q;
    sda_m <= sda_i;
    sda_q <= sda_m;
    sda_p <= sda_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= S_IDLE;
      cnt <= BIT_FIRST;
      sh <= '0;
      shift_data_reg <= '0;
      code <= ST_NO_INFO;
      done <= 1'b0;
      last <= 1'b0;
      ackd <= 1'b0;
      arb <= 1'b0;
      busy <= 1'b0;
      sent <= 1'b0;
      start_cnt <= '0;
      ctl <= '0;
      drv <= '0;
      bus_status_reg_o <= ST_NO_INFO;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      shift_data_reg <= next_data;
      code <= next_code;
      done <= next_done;
      last <= next_last;
      ackd <= next_ackd;
      arb <= next_arb;
      busy <= next_busy;
      sent <= next_sent;
      start_cnt <= next_start_cnt;
      ctl <= next_ctl;
      drv <= next_drv;
      bus_status_reg_o <= next_done ? next_code : ST_NO_INFO;
    end
  end

  // Lines only ever pull low, so the driven level is a constant zero held in a flop.
  always_ff @(posedge clk_sys_i) begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  assign scl_oe_o = drv.scl_oe;
  assign sda_oe_o = drv.sda_oe;
  assign job_done_flag_o = done;
  assign ack_enable_o = ctl.ack_enable;
  assign start_request_o = ctl.start_request;
  assign stop_request_o = ctl.stop_request;
  assign start_sent_o = sent;

  a_status_no_info: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !job_done_flag_o |-> bus_status_reg_o == ST_NO_INFO) else $error("status not f8 while done clear");
  a_prescaler_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    bus_status_reg_o[2:0] == PRESCALER_ZERO) else $error("status low bits not zero");
  a_wait_stretch: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st == S_WAIT |-> scl_oe_o && job_done_flag_o) else $error("clock not stretched while done");
  a_addr_done_code: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(job_done_flag_o) && $past(st) == S_ADDR_ACK |->
      bus_status_reg_o == ST_OWN_READ_ACK || bus_status_reg_o == ST_ARB_LOST_READ) else $error("bad address status");
  a_tx_done_code: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(job_done_flag_o) && $past(st) == S_TX_ACK |-> bus_status_reg_o ==
      (!$past(ackd) ? ST_DATA_NACK : ($past(last) ? ST_LAST_ACK : ST_DATA_ACK))) else $error("bad data status");
  a_tx_resume: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st == S_WAIT && sw_clear && send_more && ctrl_i.ack_enable |=> st == S_TX && !last && !scl_oe_o)
    else $error("byte not sent after clear");
  a_err_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    illegal |=> st == S_ERR && job_done_flag_o && bus_status_reg_o == ST_BUS_ERROR
      && !scl_oe_o && !sda_oe_o) else $error("bus error not reported");
  a_err_recover: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st == S_ERR && sw_clear && ctrl_i.stop_request && !illegal |=> st == S_IDLE && !stop_request_o
      && ack_enable_o == $past(ctrl_i.ack_enable) && !sda_oe_o && !scl_oe_o) else $error("recovery wrong");
  a_tx_scl_low: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st == S_TX && $past(st) == S_TX && $changed(sda_oe_o) |-> !scl_q) else $error("data changed with clock high");
  a_idle_release: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st == S_IDLE |-> !sda_oe_o && !scl_oe_o) else $error("lines held while not addressed");

endmodule // twi_slave_tx

// ---- inc/twi_slave_tx_pkg.sv ----
// Constants, state encoding and carrier types for the two-wire slave transmitter.
// Assumes a single 250 MHz system clock; the bus clock is sampled, never used as a clock.
package twi_slave_tx_pkg;

  localparam logic [7:0] ST_OWN_READ_ACK = 8'ha8;
  localparam logic [7:0] ST_ARB_LOST_READ = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK = 8'hc8;
  localparam logic [7:0] ST_NO_INFO = 8'hf8;
  localparam logic [7:0] ST_BUS_ERROR = 8'h00;

  localparam logic [2:0] PRESCALER_ZERO = 3'h0;
  localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;

  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_DRIVE = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;

  localparam int CLK_PERIOD_NS = 4;
  localparam int START_HOLD_NS = 4000;
  localparam int START_HOLD_CYCLES = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] START_HOLD_LAST = 10'(START_HOLD_CYCLES - 1);

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WAIT,
    S_TX,
    S_TX_ACK,
    S_ERR,
    S_START
  } state_t;

  typedef struct packed {
    logic job_done_clr;
    logic ack_enable;
    logic start_request;
    logic stop_request;
  } ctrl_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } line_drive_t;

endpackage

// ---- test/twi_master_model.sv ----
// Behavioural master receiver on the far side of the two-wire bus.
// Assumes pull-ups resolve the lines; outputs high mean released.
`timescale 1ns/1ps
module twi_master_model (
  input wire logic clk_sys_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Bus clock period is 125 ns: a quarter before the rise, half high, a quarter after the fall.
  task automatic hp;
    #62.5;
  endtask
  task automatic qp;
    #31.25;
  endtask
  task automatic start;
    sda_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_o <= 1'b0;
    hp();
    scl_o <= 1'b0;
    hp();
  endtask
  // The clock rise waits, within a bound, while the device stretches the low period.
  task automatic bit_xfer(input logic b, output logic r);
    sda_o <= b;
    qp();
    scl_o <= 1'b1;
    #1;
    for (int i = 0; i < 4000 && !scl_i; i++) @(posedge clk_sys_i);
    #61.5;
    r = sda_i;
    scl_o <= 1'b0;
    qp();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask
  task automatic stop;
    sda_o <= 1'b0;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_o <= 1'b1;
    hp();
  endtask
endmodule // twi_master_model

// ---- test/testbench.sv ----
// Self-checking bench for the two-wire slave transmitter.
// Assumes the master model on the far side and pull-ups on both lines.
`timescale 1ns/1ps
module testbench;
  import twi_slave_tx_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl_m, sda_m, scl_o, scl_oe_o, sda_o, sda_oe_o, gce, arb_lost_i, ctrl_wr_i, data_wr_i;
  logic ae, sr, so, ss, done, a;
  logic [6:0] own;
  logic [7:0] data_i, st, d;
  ctrl_t ctrl_i;
  int err_count = 0;
  int comparisons = 0;
  wire logic scl_w = scl_m & ~(scl_oe_o & ~scl_o);
  wire logic sda_w = sda_m & ~(sda_oe_o & ~sda_o);
  always #2 clk_sys_i = ~clk_sys_i;
  twi_master_model pm (.clk_sys_i(clk_sys_i), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));
  twi_slave_tx dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .own_slave_address_i(own),
    .general_call_enable_i(gce), .arb_lost_i(arb_lost_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_i(ctrl_i),
    .data_wr_i(data_wr_i), .data_i(data_i), .bus_status_reg_o(st), .job_done_flag_o(done),
    .ack_enable_o(ae), .start_request_o(sr), .stop_request_o(so), .start_sent_o(ss));
  function automatic logic [7:0] tx_code(input logic last, input logic nack);
    return nack ? ST_DATA_NACK : (last ? ST_LAST_ACK : ST_DATA_ACK);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_ctrl(input ctrl_t c, input logic [7:0] v);
    @(posedge clk_sys_i);
    ctrl_wr_i <= 1'b1;
    ctrl_i <= c;
    data_wr_i <= 1'b1;
    data_i <= v;
    @(posedge clk_sys_i);
    ctrl_wr_i <= 1'b0;
    data_wr_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic send(input logic [7:0] v, input logic last, input logic nack);
    logic [7:0] got;
    wr_ctrl({1'b1, ~last, 2'b00}, v);
    pm.rd_byte(nack, got);
    chk(got, v);
    chk(st, tx_code(last, nack));
    chk({7'h00, done}, 8'h01);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(88068));
    own = 7'($urandom_range(127, 1));
    gce = 1'b0;
    arb_lost_i = 1'b0;
    ctrl_wr_i = 1'b0;
    data_wr_i = 1'b0;
    ctrl_i = '0;
    data_i = '0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk(st, ST_NO_INFO);
    wr_ctrl(4'b0100, 8'h00);
    pm.start();
    pm.wr_byte({own, 1'b1}, a);
    chk({7'h00, a}, 8'h00);
    chk(st, ST_OWN_READ_ACK);
    chk({7'h00, scl_oe_o}, 8'h01);
    send(8'h80, 1'b0, 1'b0);
    send(8'($urandom), 1'b1, 1'b0);
    wr_ctrl(4'b1000, 8'h00);
    chk(st, ST_NO_INFO);
    pm.rd_byte(1'b1, d);
    chk(d, 8'hff);
    pm.stop();
    pm.start();
    pm.wr_byte({own, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
    pm.stop();
    $display("test own address done");
    wr_ctrl(4'b0100, 8'h00);
    pm.start();
    pm.wr_byte(8'h01, a);
    chk({7'h00, a}, 8'h01);
    pm.stop();
    @(posedge clk_sys_i) gce <= 1'b1;
    pm.start();
    pm.wr_byte(8'h01, a);
    chk(st, ST_OWN_READ_ACK);
    send(8'($urandom), 1'b0, 1'b1);
    wr_ctrl(4'b1110, 8'h00);
    repeat (60) @(posedge clk_sys_i);
    chk({7'h00, sda_oe_o}, 8'h00);
    pm.stop();
    for (int i = 0; i < 300 && !sda_oe_o; i++) @(posedge clk_sys_i);
    chk({6'h00, sda_oe_o, scl_oe_o}, 8'h02);
    for (int i = 0; i < 1200 && !ss; i++) @(posedge clk_sys_i);
    chk({6'h00, ss, scl_oe_o}, 8'h03);
    wr_ctrl(4'b1100, 8'h00);
    chk({6'h00, sda_oe_o, scl_oe_o}, 8'h00);
    $display("test general call and start done");
    @(posedge clk_sys_i);
    arb_lost_i <= 1'b1;
    @(posedge clk_sys_i);
    arb_lost_i <= 1'b0;
    pm.start();
    pm.wr_byte({own, 1'b1}, a);
    chk(st, ST_ARB_LOST_READ);
    send(8'($urandom), 1'b1, 1'b1);
    wr_ctrl(4'b1100, 8'h00);
    pm.stop();
    $display("test arbitration done");
    pm.start();
    repeat (3) pm.bit_xfer(1'b1, a);
    pm.start();
    repeat (4) @(posedge clk_sys_i);
    chk(st, ST_BUS_ERROR);
    chk({7'h00, done}, 8'h01);
    chk({6'h00, sda_oe_o, scl_oe_o}, 8'h00);
    wr_ctrl(4'b1101, 8'h00);
    chk({4'h0, ae, sr, so, done}, 8'h08);
    chk({6'h00, sda_oe_o, scl_oe_o}, 8'h00);
    chk(st, ST_NO_INFO);
    pm.stop();
    $display("test bus error done");
    results();
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule // testbench
